// ===== rtl/alu_ext_pkg.sv
// Purpose: constants and types for the sign-widen / bcd-adjust / divide datapath
// Assumes: single core clock, operands supplied by decoder and register file
// Notes:   widths and flag masks live here only
package alu_ext_pkg;
    localparam int          DATA_W      = 32;
    localparam int          SIZE_W      = 2;
    localparam logic [1:0]  SIZE_8      = 2'h0;
    localparam logic [1:0]  SIZE_16     = 2'h1;
    localparam logic [1:0]  SIZE_32     = 2'h2;
    localparam int          BIT_W15     = 15;
    localparam int          BIT_W31     = 31;
    localparam logic [3:0]  NIB_MAX     = 4'h9;
    localparam logic [7:0]  LO_ADJ      = 8'h06;
    localparam logic [7:0]  HI_ADJ      = 8'h60;
    localparam logic [7:0]  HI_MASK     = 8'hF0;
    localparam logic [7:0]  ADD_HI_LIM  = 8'h90;
    localparam logic [7:0]  SUB_HI_LIM  = 8'h9F;
    localparam logic [31:0] QMAX_8      = 32'h000000FF;
    localparam logic [31:0] QMAX_16     = 32'h0000FFFF;
    localparam logic [31:0] QMAX_32     = 32'hFFFFFFFF;
    localparam int          DIV_STEPS   = 64;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_SIGN_WIDEN,
        OP_BCD_ADD_ADJ,
        OP_BCD_SUB_ADJ,
        OP_MINUS_ONE,
        OP_UDIV
    } alu_op_t;

    typedef enum {
        ST_IDLE,
        ST_DIV
    } div_state_t;
endpackage

// ===== rtl/sign_widen_bcd_adjust_divide_alu.sv
// Purpose: execution datapath for sign widening, packed-bcd adjust, minus-one and unsigned divide
// Assumes: op_valid_i is a one-cycle pulse, no new op while busy_o is high
// Notes:   divide is restoring, one quotient bit per clock; others answer next cycle
//
// Summary of operation
// - word widen copies acc bit 15 into all 16 extension bits.
// - dword widen copies acc bit 31 into all 32 extension bits.
// - one opcode; operand size 16 picks word form, 32 picks dword form.
// - add adjust: low nibble over 9 or aux set adds 6, carry ORed, aux set.
// - add adjust: byte&F0 over 90 or carry adds 60 and sets carry, else clears.
// - sub adjust: low nibble over 9 or aux set subtracts 6, borrow ORed.
// - sub adjust: byte over 9F or carry subtracts 60, sets carry, else clears.
// - after bcd adjust, sign, zero, parity follow the adjusted byte.
// - minus-one subtracts 1, keeps carry, sets other flags from result.
// - divide places quotient low, remainder high; oversize quotient faults.
// - zero divisor or oversize quotient faults and writes no result.
// - quotient truncates toward zero; remainder below divisor.
// - flags after divide are undefined; this design leaves them unchanged.
// - widening alters no arithmetic flags.
`timescale 1ns/1ps
`default_nettype none
module sign_widen_bcd_adjust_divide_alu
    import alu_ext_pkg::*;
#(
    parameter int W = DATA_W
) (
    // clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          nrst_i,
    // request from decoder
    input  wire logic          op_valid_i,
    input  wire alu_op_t       op_i,
    input  wire logic [1:0]    op_size_i,
    input  wire logic [W-1:0]  acc_dword_i,
    input  wire logic [W-1:0]  ext_dword_i,
    input  wire logic [W-1:0]  src_i,
    // incoming flags
    input  wire logic          carry_flag_i,
    input  wire logic          aux_carry_flag_i,
    input  wire logic          overflow_flag_i,
    input  wire logic          sign_flag_i,
    input  wire logic          zero_flag_i,
    input  wire logic          parity_flag_i,
    // results to register file
    output logic               done_o,
    output logic               busy_o,
    output logic               quotient_fault_o,
    output logic               acc_we_o,
    output logic               ext_we_o,
    output logic               dst_we_o,
    output logic [W-1:0]       acc_dword_o,
    output logic [W-1:0]       ext_dword_o,
    output logic [W-1:0]       dst_o,
    output logic               flags_we_o,
    output logic               carry_flag_o,
    output logic               aux_carry_flag_o,
    output logic               overflow_flag_o,
    output logic               sign_flag_o,
    output logic               zero_flag_o,
    output logic               parity_flag_o
);

    // divider and flag logic are sized for 32 bits only
    if (W != DATA_W) begin : g_width_check
        $error("only 32-bit datapath supported");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic even_parity(input logic [7:0] b);
        even_parity = ~^b;
    endfunction

    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        case (sz)
            SIZE_8:  size_mask = QMAX_8;
            SIZE_16: size_mask = QMAX_16;
            default: size_mask = QMAX_32;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // single-cycle ops

    logic [7:0]  bcd_byte;
    logic        bcd_cf;
    logic        bcd_af;
    logic [8:0]  lo_sum;
    logic [7:0]  stage1;
    logic        lo_hit;
    logic        hi_hit;
    logic [31:0] dec_res;
    logic        dec_of;
    logic [31:0] dec_msk;
    logic [31:0] dec_src;

    always_comb begin
        bcd_af = 1'b0;
        bcd_cf = carry_flag_i;
        lo_sum = 9'h000;
        lo_hit = (acc_dword_i[3:0] > NIB_MAX) || aux_carry_flag_i;
        if (op_i == OP_BCD_ADD_ADJ) begin
            if (lo_hit) begin
                lo_sum = {1'b0, acc_dword_i[7:0]} + {1'b0, LO_ADJ};
                bcd_cf = carry_flag_i | lo_sum[8];
                bcd_af = 1'b1;
            end else begin
                lo_sum = {1'b0, acc_dword_i[7:0]};
            end
            stage1 = lo_sum[7:0];
            // high test sees byte and carry left by the low step, so 9A..9F still wrap
            hi_hit = ((stage1 & HI_MASK) > ADD_HI_LIM) || bcd_cf;
            bcd_byte = hi_hit ? stage1 + HI_ADJ : stage1;
            bcd_cf = hi_hit;
        end else begin
            if (lo_hit) begin
                lo_sum = {1'b0, acc_dword_i[7:0]} - {1'b0, LO_ADJ};
                bcd_cf = carry_flag_i | lo_sum[8];
                bcd_af = 1'b1;
            end else begin
                lo_sum = {1'b0, acc_dword_i[7:0]};
            end
            stage1 = lo_sum[7:0];
            hi_hit = (stage1 > SUB_HI_LIM) || bcd_cf;
            bcd_byte = hi_hit ? stage1 - HI_ADJ : stage1;
            bcd_cf = hi_hit;
        end
    end

    always_comb begin
        dec_msk = size_mask(op_size_i);
        dec_src = src_i & dec_msk;
        dec_res = (dec_src - 32'h00000001) & dec_msk;
        case (op_size_i)
            SIZE_8:  dec_of = (dec_src == 32'h00000080);
            SIZE_16: dec_of = (dec_src == 32'h00008000);
            default: dec_of = (dec_src == 32'h80000000);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // divide engine: restoring, dividend up to 64 bits

    div_state_t  st_r;
    logic [63:0] dvd_r;
    logic [32:0] rem_r;
    logic [31:0] dvs_r;
    logic [6:0]  cnt_r;
    logic [1:0]  dsz_r;
    logic [63:0] dvd_ld;
    logic [32:0] rem_sh;
    logic        ge;

    always_comb begin
        case (op_size_i)
            SIZE_8:  dvd_ld = {48'h000000000000, acc_dword_i[15:0]};
            SIZE_16: dvd_ld = {32'h00000000, ext_dword_i[15:0], acc_dword_i[15:0]};
            default: dvd_ld = {ext_dword_i, acc_dword_i};
        endcase
        rem_sh = {rem_r[31:0], dvd_r[63]};
        ge = rem_sh >= {1'b0, dvs_r};
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            st_r  <= ST_IDLE;
            dvd_r <= 64'h0000000000000000;
            rem_r <= 33'h000000000;
            dvs_r <= 32'h00000000;
            cnt_r <= 7'h00;
            dsz_r <= SIZE_8;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (op_valid_i && op_i == OP_UDIV && (src_i & size_mask(op_size_i)) != 32'h0) begin
                        st_r  <= ST_DIV;
                        dvd_r <= dvd_ld;
                        rem_r <= 33'h000000000;
                        dvs_r <= src_i & size_mask(op_size_i);
                        cnt_r <= 7'(DIV_STEPS);
                        dsz_r <= op_size_i;
                    end
                end
                ST_DIV: begin
                    // quotient bits shift into dvd_r, truncating toward zero
                    rem_r <= ge ? rem_sh - {1'b0, dvs_r} : rem_sh;
                    dvd_r <= {dvd_r[62:0], ge};
                    cnt_r <= cnt_r - 7'h01;
                    if (cnt_r == 7'h01) st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    logic        div_last;
    logic [31:0] q_fin;
    logic [31:0] r_fin;
    logic        q_big;

    always_comb begin
        div_last = (st_r == ST_DIV) && (cnt_r == 7'h01);
        q_fin = {dvd_r[30:0], ge};
        r_fin = ge ? 32'(rem_sh - {1'b0, dvs_r}) : rem_sh[31:0];
        // full 64-bit quotient checked against size limit
        q_big = (dvd_r[62:31] != 32'h0) || (q_fin > size_mask(dsz_r));
    end

    ////////////////////////////////////////////////////////////////////////
    // result registers

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            done_o <= 1'b0;
            busy_o <= 1'b0;
            quotient_fault_o <= 1'b0;
            acc_we_o <= 1'b0;
            ext_we_o <= 1'b0;
            dst_we_o <= 1'b0;
            flags_we_o <= 1'b0;
            acc_dword_o <= 32'h00000000;
            ext_dword_o <= 32'h00000000;
            dst_o <= 32'h00000000;
            carry_flag_o <= 1'b0;
            aux_carry_flag_o <= 1'b0;
            overflow_flag_o <= 1'b0;
            sign_flag_o <= 1'b0;
            zero_flag_o <= 1'b0;
            parity_flag_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            quotient_fault_o <= 1'b0;
            acc_we_o <= 1'b0;
            ext_we_o <= 1'b0;
            dst_we_o <= 1'b0;
            flags_we_o <= 1'b0;
            busy_o <= (st_r == ST_IDLE) ? (op_valid_i && op_i == OP_UDIV
                      && (src_i & size_mask(op_size_i)) != 32'h0) : !div_last;
            if (op_valid_i && st_r == ST_IDLE) begin
                case (op_i)
                    OP_SIGN_WIDEN: begin
                        done_o <= 1'b1;
                        ext_we_o <= 1'b1;
                        if (op_size_i == SIZE_16)
                            ext_dword_o <= {ext_dword_i[31:16], {16{acc_dword_i[BIT_W15]}}};
                        else
                            ext_dword_o <= {32{acc_dword_i[BIT_W31]}};
                    end
                    OP_BCD_ADD_ADJ, OP_BCD_SUB_ADJ: begin
                        done_o <= 1'b1;
                        acc_we_o <= 1'b1;
                        flags_we_o <= 1'b1;
                        acc_dword_o <= {acc_dword_i[31:8], bcd_byte};
                        carry_flag_o <= bcd_cf;
                        aux_carry_flag_o <= bcd_af;
                        overflow_flag_o <= overflow_flag_i;               // undefined: kept
                        sign_flag_o <= bcd_byte[7];
                        zero_flag_o <= (bcd_byte == 8'h00);
                        parity_flag_o <= even_parity(bcd_byte);
                    end
                    OP_MINUS_ONE: begin
                        done_o <= 1'b1;
                        dst_we_o <= 1'b1;
                        flags_we_o <= 1'b1;
                        dst_o <= (src_i & ~size_mask(op_size_i)) | dec_res;
                        carry_flag_o <= carry_flag_i;
                        overflow_flag_o <= dec_of;
                        aux_carry_flag_o <= (dec_src[3:0] == 4'h0);
                        sign_flag_o <= (op_size_i == SIZE_8) ? dec_res[7] :
                                       (op_size_i == SIZE_16) ? dec_res[15] : dec_res[31];
                        zero_flag_o <= (dec_res == 32'h0);
                        parity_flag_o <= even_parity(dec_res[7:0]);
                    end
                    OP_UDIV: begin
                        if ((src_i & size_mask(op_size_i)) == 32'h0) begin
                            done_o <= 1'b1;
                            quotient_fault_o <= 1'b1;
                        end
                    end
                    default: done_o <= 1'b1;
                endcase
            end
            if (div_last) begin
                done_o <= 1'b1;
                // flags undefined after divide: no flag write at all
                if (q_big) begin
                    quotient_fault_o <= 1'b1;
                end else begin
                    acc_we_o <= 1'b1;
                    if (dsz_r == SIZE_8) begin
                        acc_dword_o <= {acc_dword_i[31:16], r_fin[7:0], q_fin[7:0]};
                    end else if (dsz_r == SIZE_16) begin
                        ext_we_o <= 1'b1;
                        acc_dword_o <= {acc_dword_i[31:16], q_fin[15:0]};
                        ext_dword_o <= {ext_dword_i[31:16], r_fin[15:0]};
                    end else begin
                        ext_we_o <= 1'b1;
                        acc_dword_o <= q_fin;
                        ext_dword_o <= r_fin;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== tb/alu_ext_assertions.sv
// Purpose: port-level checks for the widen / bcd / minus-one / divide datapath
// Assumes: one clock, synchronous active-low reset
// Notes:   divide answer pinned to the 64-step count after the take
`timescale 1ns/1ps
`default_nettype none
module alu_ext_assertions
    import alu_ext_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // request side
    input  wire logic        op_valid_i,
    input  wire alu_op_t     op_i,
    input  wire logic [1:0]  op_size_i,
    input  wire logic [31:0] acc_dword_i,
    input  wire logic [31:0] src_i,
    input  wire logic        carry_flag_i,
    // result side
    input  wire logic        done_o,
    input  wire logic        busy_o,
    input  wire logic        quotient_fault_o,
    input  wire logic        acc_we_o,
    input  wire logic        ext_we_o,
    input  wire logic        dst_we_o,
    input  wire logic        flags_we_o,
    input  wire logic [31:0] acc_dword_o,
    input  wire logic [31:0] ext_dword_o,
    input  wire logic [31:0] dst_o,
    input  wire logic        carry_flag_o,
    input  wire logic        sign_flag_o,
    input  wire logic        zero_flag_o,
    input  wire logic        parity_flag_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic take = op_valid_i && !busy_o;
    ////////////////////////////////////////////////////////////////////////
    widen_word_a: assert property (
        take && op_i == OP_SIGN_WIDEN && op_size_i == SIZE_16 |=> done_o && ext_we_o
        && ext_dword_o[15:0] == {16{$past(acc_dword_i[15])}}) else $error("word widen wrong");
    widen_dword_a: assert property (
        take && op_i == OP_SIGN_WIDEN && op_size_i == SIZE_32 |=> done_o && ext_we_o
        && ext_dword_o == {32{$past(acc_dword_i[31])}}) else $error("dword widen wrong");
    widen_flags_a: assert property (flags_we_o |-> !ext_we_o) else $error("flags written with ext");
    widen_noflag_a: assert property (
        take && op_i == OP_SIGN_WIDEN |=> done_o && !flags_we_o && !acc_we_o) else $error("widen touched flags");
    bcd_flags_a: assert property (
        flags_we_o && acc_we_o |-> sign_flag_o == acc_dword_o[7] && zero_flag_o == (acc_dword_o[7:0] == 8'h00)
        && parity_flag_o == ~^acc_dword_o[7:0]) else $error("bcd flags wrong");
    dec_carry_a: assert property (
        take && op_i == OP_MINUS_ONE |=> dst_we_o && flags_we_o && carry_flag_o == $past(carry_flag_i)
        && dst_o[7:0] == $past(src_i[7:0]) - 8'h01) else $error("minus-one wrong");
    zero_div_a: assert property (
        take && op_i == OP_UDIV && src_i == 32'h0 |=> done_o && quotient_fault_o) else $error("zero divisor");
    fault_nowrite_a: assert property (
        quotient_fault_o |-> done_o && !(acc_we_o || ext_we_o || dst_we_o || flags_we_o))
        else $error("fault wrote result");
    div_busy_a: assert property (
        take && op_i == OP_UDIV && src_i[7:0] != 8'h00 |=> busy_o [*8] ##57 (done_o && !busy_o))
        else $error("divide timing");
    busy_quiet_a: assert property (busy_o |-> !done_o) else $error("done while busy");
endmodule
`default_nettype wire

// ===== tb/regfile_model.sv
// Purpose: register file seen by the datapath, operands passed to it
// Assumes: bench drives raw operands at any time
// Notes:   operands freeze while busy, the bench scrambles them meanwhile
`timescale 1ns/1ps
`default_nettype none
module regfile_model (
    // clock and freeze
    input  wire logic         ref_clk_i,
    input  wire logic         busy_i,
    // bench side
    input  wire logic [101:0] ops_i,
    // datapath side
    output logic      [101:0] ops_o
);
    logic [101:0] hold_r;
    always_ff @(posedge ref_clk_i) begin
        if (!busy_i) begin
            hold_r <= ops_i;
        end
    end
    // held copy only while busy, otherwise no kinder than raw values
    assign ops_o = busy_i ? hold_r : ops_i;
endmodule
`default_nettype wire

// ===== tb/sign_widen_bcd_adjust_divide_alu_bench.sv
// Purpose: self-checking bench for the widen / bcd / minus-one / divide datapath
// Assumes: inputs driven at falling edge, results checked from a queue
// Notes:   random operands from xorshift, edge values forced by masks
`timescale 1ns/1ps
`default_nettype none
module sign_widen_bcd_adjust_divide_alu_bench;
    import alu_ext_pkg::*;
    typedef struct packed {logic [4:0] we; logic [31:0] acc, ext, dst; logic [5:0] fl;} exp_t;
    logic        ref_clk_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0;
    alu_op_t     op_i = OP_NONE;
    logic [1:0]  op_size_i = SIZE_32;
    logic [31:0] acc_r = 32'h0, ext_r = 32'h0, src_r = 32'h0, rnd_r = 32'h1C9D5183;
    logic [5:0]  flg_r = 6'h00;
    wire logic [31:0] acc_w, ext_w, src_w, acc_o, ext_o, dst_o;
    wire logic [5:0]  flg_w, flo;
    wire logic [3:0]  we_o;
    wire logic        done_o, busy_o, qf_o;
    exp_t        ex;
    exp_t        q_e[$];
    int          fails = 0, n_tests = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////
    regfile_model pm_u (.ref_clk_i(ref_clk_i), .busy_i(busy_o), .ops_i({acc_r, ext_r, src_r, flg_r}),
        .ops_o({acc_w, ext_w, src_w, flg_w}));
    sign_widen_bcd_adjust_divide_alu dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .op_size_i(op_size_i), .acc_dword_i(acc_w), .ext_dword_i(ext_w), .src_i(src_w),
        .carry_flag_i(flg_w[5]), .aux_carry_flag_i(flg_w[4]), .overflow_flag_i(flg_w[3]),
        .sign_flag_i(flg_w[2]), .zero_flag_i(flg_w[1]), .parity_flag_i(flg_w[0]), .done_o(done_o),
        .busy_o(busy_o), .quotient_fault_o(qf_o), .acc_we_o(we_o[3]), .ext_we_o(we_o[2]), .dst_we_o(we_o[1]),
        .acc_dword_o(acc_o), .ext_dword_o(ext_o), .dst_o(dst_o), .flags_we_o(we_o[0]),
        .carry_flag_o(flo[5]), .aux_carry_flag_o(flo[4]), .overflow_flag_o(flo[3]), .sign_flag_o(flo[2]),
        .zero_flag_o(flo[1]), .parity_flag_o(flo[0]));
    always #20 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic exp_t model(alu_op_t o, logic [1:0] sz);
        exp_t e;
        logic [63:0] dd, q, r;
        logic [31:0] m, hb;
        logic [7:0] t;
        logic cf, af;
        e = {5'h0, acc_r, ext_r, src_r, flg_r};
        m = sz == SIZE_8 ? QMAX_8 : sz == SIZE_16 ? QMAX_16 : QMAX_32;
        hb = (m >> 1) + 32'h1;
        case (o)
            OP_SIGN_WIDEN: begin
                e.we = 5'h04;
                e.ext = sz == SIZE_16 ? {ext_r[31:16], {16{acc_r[15]}}} : {32{acc_r[31]}};
            end
            OP_BCD_ADD_ADJ, OP_BCD_SUB_ADJ: begin
                af = acc_r[3:0] > NIB_MAX || flg_r[4];
                t = af ? (o == OP_BCD_ADD_ADJ ? acc_r[7:0] + LO_ADJ : acc_r[7:0] - LO_ADJ) : acc_r[7:0];
                // low-step carry or borrow joins the incoming carry before the high test
                cf = flg_r[5] || (af && (o == OP_BCD_ADD_ADJ ? acc_r[7:0] > 8'hF9 : acc_r[7:0] < LO_ADJ));
                cf = cf || (o == OP_BCD_ADD_ADJ ? (t & HI_MASK) > ADD_HI_LIM : t > SUB_HI_LIM);
                t = cf ? (o == OP_BCD_ADD_ADJ ? t + HI_ADJ : t - HI_ADJ) : t;
                e.we = 5'h09;
                e.acc = {acc_r[31:8], t};
                e.fl = {cf, af, flg_r[3], t[7], t == 8'h00, ~^t};
            end
            OP_MINUS_ONE: begin
                e.we = 5'h03;
                e.dst = (src_r & ~m) | ((src_r - 32'h1) & m);
                e.fl = {flg_r[5], src_r[3:0] == 4'h0, (src_r & m) == hb, (e.dst & hb) != 0, (e.dst & m) == 0, ~^e.dst[7:0]};
            end
            OP_UDIV: begin
                dd = sz == SIZE_8 ? {48'h0, acc_r[15:0]} : sz == SIZE_16 ? {32'h0, ext_r[15:0], acc_r[15:0]} : {ext_r, acc_r};
                e.we = 5'h10;
                if ((src_r & m) != 0) begin
                    q = dd / (src_r & m);
                    r = dd % (src_r & m);
                    if (q <= m && sz == SIZE_8) begin
                        e.we = 5'h08;
                        e.acc = {acc_r[31:16], r[7:0], q[7:0]};
                    end else if (q <= m) begin
                        e.we = 5'h0C;
                        e.acc = (acc_r & ~m) | (q[31:0] & m);
                        e.ext = (ext_r & ~m) | (r[31:0] & m);
                    end
                end
            end
            default: e.we = 5'h00;
        endcase
        return e;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [31:0] e, logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic roll();
        rnd_r = xs(rnd_r);
        acc_r = rnd_r;
        rnd_r = xs(rnd_r);
        ext_r = rnd_r;
        rnd_r = xs(rnd_r);
        src_r = rnd_r;
        flg_r = rnd_r[13:8];
    endtask
    // caller stands on a falling edge with operands already rolled for this request
    task automatic issue(alu_op_t o, logic [1:0] sz);
        op_valid_i = 1'b1;
        op_i = o;
        op_size_i = sz;
        q_e.push_back(model(o, sz));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // results are read at the falling edge, well clear of the launch edge
    always @(negedge ref_clk_i) begin
        if (done_o === 1'b1 && q_e.size() == 0) begin
            check("extra done", 32'h0, 32'h1);
        end else if (done_o === 1'b1) begin
            ex = q_e.pop_front();
            check("write enables", {27'h0, ex.we}, {27'h0, qf_o, we_o});
            if (ex.we[3]) check("acc", ex.acc, acc_o);
            if (ex.we[2]) check("ext", ex.ext, ext_o);
            if (ex.we[1]) check("dst", ex.dst, dst_o);
            if (ex.we[0]) check("flags", {26'h0, ex.fl}, {26'h0, flo});
        end
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        // one-cycle ops back to back, every op against every size
        for (int i = 0; i < 60; i++) begin
            @(negedge ref_clk_i);
            roll();
            if (i % 7 == 0) src_r = src_r & 32'h80008000;
            if (i % 10 == 2) acc_r[7:0] = 8'h9A;
            if (i % 10 == 3) {acc_r[7:0], flg_r[4]} = {8'h03, 1'b1};
            issue(alu_op_t'(i % 5), 2'(i % 3));
        end
        @(negedge ref_clk_i) op_valid_i = 1'b0;
        // divide: good quotient, zero divisor, oversize quotient at each size
        for (int i = 0; i < 9; i++) begin
            @(negedge ref_clk_i);
            roll();
            src_r = src_r | 32'h80808080;
            acc_r = acc_r & 32'hFFFF7FFF;
            ext_r = ext_r & 32'h7FFF7FFF;
            if (i / 3 == 1) src_r = 32'h0;
            if (i / 3 == 2) {src_r, acc_r[15:8], ext_r} = {32'h1, 8'hFF, 32'hFFFFFFFF};
            issue(OP_UDIV, 2'(i % 3));
            @(negedge ref_clk_i) op_valid_i = 1'b0;
            roll();
            // a request while busy must vanish without a done
            @(negedge ref_clk_i) op_valid_i = (i / 3 == 0);
            op_i = OP_NONE;
            @(negedge ref_clk_i) op_valid_i = 1'b0;
            for (int k = 0; k < 100 && busy_o !== 1'b0; k++) @(negedge ref_clk_i);
        end
        repeat (4) @(negedge ref_clk_i);
        check("pending results", 32'h0, q_e.size());
        tally_and_finish();
    end
endmodule
bind sign_widen_bcd_adjust_divide_alu alu_ext_assertions chk_u (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_i(op_i), .op_size_i(op_size_i),
    .acc_dword_i(acc_dword_i), .src_i(src_i), .carry_flag_i(carry_flag_i), .done_o(done_o), .busy_o(busy_o),
    .quotient_fault_o(quotient_fault_o), .acc_we_o(acc_we_o), .ext_we_o(ext_we_o), .dst_we_o(dst_we_o),
    .flags_we_o(flags_we_o), .acc_dword_o(acc_dword_o), .ext_dword_o(ext_dword_o), .dst_o(dst_o),
    .carry_flag_o(carry_flag_o), .sign_flag_o(sign_flag_o), .zero_flag_o(zero_flag_o),
    .parity_flag_o(parity_flag_o));
`default_nettype wire
